/* fbd_map.vh */
// Address map, field positions, reset values and timing of the line monitor.
`ifndef FBD_MAP_VH
`define FBD_MAP_VH

// Register byte offsets.
`define FBD_REG_CTRL       8'h00
`define FBD_REG_STATUS     8'h04
`define FBD_REG_MASK       8'h08
`define FBD_REG_STATE      8'h0c

// Control register fields and reset value.
`define FBD_CTRL_INHIBIT   0
`define FBD_CTRL_RST       1'h0

// Status and mask fields (same layout).
`define FBD_EV_SYMBOL      0
`define FBD_EV_OVERLOAD    1
`define FBD_EV_UNDERLOAD   2
`define FBD_EV_JABBER      3
`define FBD_EV_CARRIER     4
`define FBD_EV_W           5
`define FBD_EV_RST         5'h00

// State register fields.
`define FBD_ST_FAULT       0
`define FBD_ST_JABBER      1
`define FBD_ST_CARRIER     2
`define FBD_ST_LONG        3
`define FBD_ST_SEL_A       4
`define FBD_ST_SEL_B       5

// Times in bit periods.
`define FBD_SYMBOL_TBIT    4
`define FBD_JABBER_TBIT    8192
`define FBD_RELEASE_TBIT_X2 7
`define FBD_LONG_TBIT      6
`define FBD_CD_DELAY_TBIT  6

// Tick rates: half_bit_clk rises twice per bit, error_detect_clk edges
// come four times per bit.
`define FBD_HALF_PER_TBIT  2
`define FBD_QTR_PER_TBIT   4

`endif

/* fbd_tick_counter.v */
// Saturating counter of enable ticks with a reach flag.
`timescale 1ns/1ps
`default_nettype none

module fbd_tick_counter
#(
   parameter W     = 8,
   parameter LIMIT = 8
)
(
   input  wire         clock,    // System clock.
   input  wire         nrst,     // Synchronous reset, active low.
   input  wire         clear,    // Restart count from zero.
   input  wire         tick,     // One-cycle rate enable.
   output wire         reached   // Count has reached LIMIT.
);

   localparam [W-1:0] LIM = LIMIT[W-1:0];

   reg [W-1:0] count_ff;
   reg [W-1:0] nxt_count;

   assign reached = (count_ff == LIM);

   // Saturation keeps the flag standing until the next clear.
   always @*
   begin
      nxt_count = count_ff;
      if (clear)
         nxt_count = {W{1'b0}};
      else if (tick && !reached)
         nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
   end

   always @(posedge clock)
   begin
      if (!nrst)
         count_ff <= {W{1'b0}};
      else
         count_ff <= nxt_count;
   end

endmodule

`default_nettype wire

/* fbd_line_monitor.v */
// Transmit monitoring, carrier detection, test modes and APB registers.
// What this block does
// - Drivers go high impedance whenever transmit drive enable is inactive.
// - Flag transmit fault when a transmitted symbol exceeds four bit periods.
// - Flag transmit fault on driver overload or underload.
// - Raise jabber alarm when one frame exceeds 8192 bit periods.
// - Jabber alarm holds until chip initialization input or reset; nothing else clears.
// - Selects 00 normal; 01 normal with carrier output delayed six bits.
// - Selects 10 loop transmit data to receive, enable to carrier.
// - Selects 11 loopback with fault forced high, jabber alarm low.
// - Carrier qualifies after comparator high for 0.25 to 0.5 bits.
// - Carrier released after 3.5 bits without a valid carrier pulse.
// - Long carrier indication holds six bits more before release.
// - Comparator sampled on every error clock edge; two successive samples reject glitches.
// - Each carrier set pulse sets both carrier indications.
// - Carrier indication drops after a release period with no set pulse.
// - Long carrier drops one hold time later; qualification then restarts.
`timescale 1ns/1ps
`default_nettype none
`include "fbd_map.vh"

module fbd_line_monitor
#(
   parameter JABBER_TICKS = `FBD_JABBER_TBIT * `FBD_HALF_PER_TBIT
)
(
   input  wire        clock,            // 250 MHz system clock.
   input  wire        nrst,             // Synchronous reset, active low.
   input  wire        chip_init_n,      // Chip initialization, active low.
   input  wire        test_sel_a,       // First test select.
   input  wire        test_sel_b,       // Second test select.
   input  wire        error_detect_clk, // Error clock, two periods per bit.
   input  wire        half_bit_clk,     // Half-bit clock.
   input  wire        tx_data,          // Transmit data.
   input  wire        tx_drive_enable,  // Transmit drive enable.
   input  wire        drv_overload,     // Driver load current too high.
   input  wire        drv_underload,    // Driver load current too low.
   input  wire        rx_cmp,           // Window comparator, line active.
   input  wire        rx_level,         // Hysteresis comparator output.
   output reg         line_drv_p,       // Positive driver data.
   output reg         line_drv_n,       // Negative driver data.
   output reg         line_drv_oe_n,    // Driver enable, low while driving.
   output reg         rx_data,          // Received data.
   output reg         carrier_sense_n,  // Carrier detect, active low.
   output reg         tx_fault_flag,    // Transmit fault, active high.
   output reg         jabber_alarm_n,   // Jabber alarm, active low.
   output reg         irq,              // Level interrupt, active high.
   input  wire        psel,             // APB select.
   input  wire        penable,          // APB enable.
   input  wire        pwrite,           // APB direction.
   input  wire [7:0]  paddr,            // APB byte address.
   input  wire [31:0] pwdata,           // APB write data.
   output reg  [31:0] prdata,           // APB read data.
   output reg         pready,           // APB ready.
   output reg         pslverr           // APB error, unmapped address.
);

   localparam SYM_TICKS = `FBD_SYMBOL_TBIT * `FBD_HALF_PER_TBIT + 1;
   localparam REL_TICKS = `FBD_RELEASE_TBIT_X2 * `FBD_QTR_PER_TBIT / 2;
   localparam LNG_TICKS = `FBD_LONG_TBIT * `FBD_QTR_PER_TBIT;
   localparam DLY_TICKS = `FBD_CD_DELAY_TBIT * `FBD_QTR_PER_TBIT;

   localparam [1:0] MODE_NORMAL = 2'b00;
   localparam [1:0] MODE_DELAY  = 2'b01;
   localparam [1:0] MODE_LOOP   = 2'b10;
   localparam [1:0] MODE_LOOPF  = 2'b11;

   wire [1:0] mode = {test_sel_a, test_sel_b};
   wire       init = !chip_init_n;

   // Edge detectors on the supplied clocks; they are synchronous inputs.
   reg edc_q_ff;
   reg hbc_q_ff;
   wire qtick = (error_detect_clk != edc_q_ff);
   wire htick = half_bit_clk && !hbc_q_ff;

   always @(posedge clock)
   begin
      if (!nrst)
      begin
         edc_q_ff <= 1'b0;
         hbc_q_ff <= 1'b0;
      end
      else
      begin
         edc_q_ff <= error_detect_clk;
         hbc_q_ff <= half_bit_clk;
      end
   end

   // Transmit side.
   reg  txd_q_ff;
   reg  jabber_ff;
   reg  ctrl_inhibit_ff;
   wire sym_over;
   wire jab_over;
   wire tx_active = tx_drive_enable;

   always @(posedge clock)
   begin
      if (!nrst)
         txd_q_ff <= 1'b0;
      else
         txd_q_ff <= tx_data;
   end

   // A symbol ends at every data change; idle time is not a symbol.
   fbd_tick_counter #(.W(4), .LIMIT(SYM_TICKS)) u_symbol
   (
      .clock   (clock),
      .nrst    (nrst),
      .clear   (init || !tx_active || (tx_data != txd_q_ff)),
      .tick    (htick),
      .reached (sym_over)
   );

   // Frame length is the whole time the drive enable stands.
   fbd_tick_counter #(.W(15), .LIMIT(JABBER_TICKS)) u_jabber
   (
      .clock   (clock),
      .nrst    (nrst),
      .clear   (init || !tx_active),
      .tick    (htick),
      .reached (jab_over)
   );

   wire nxt_jabber = init ? 1'b0 : (jabber_ff || jab_over);
   wire fault_now  = !init && ((tx_active && sym_over)
                     || drv_overload || drv_underload);

   always @(posedge clock)
   begin
      if (!nrst)
         jabber_ff <= 1'b0;
      else
         jabber_ff <= nxt_jabber;
   end

   // Carrier side: two successive error clock edges must both see the
   // comparator active, which rejects glitches shorter than a quarter bit.
   reg  samp_a_ff;
   reg  icd_ff;
   reg  ilcd_ff;
   wire rel_over;
   wire lng_over;
   wire set_pulse = qtick && samp_a_ff && rx_cmp && !ilcd_ff;

   always @(posedge clock)
   begin
      if (!nrst)
         samp_a_ff <= 1'b0;
      else if (init || (ilcd_ff && !icd_ff && lng_over))
         samp_a_ff <= 1'b0;
      else if (qtick)
         samp_a_ff <= rx_cmp;
   end

   // While the long indication holds, set pulses retrigger the carrier.
   wire carrier_set_pulse = set_pulse
                            || (qtick && ilcd_ff && samp_a_ff && rx_cmp);

   fbd_tick_counter #(.W(5), .LIMIT(REL_TICKS)) u_release
   (
      .clock   (clock),
      .nrst    (nrst),
      .clear   (init || carrier_set_pulse),
      .tick    (qtick && icd_ff),
      .reached (rel_over)
   );

   fbd_tick_counter #(.W(5), .LIMIT(LNG_TICKS)) u_long
   (
      .clock   (clock),
      .nrst    (nrst),
      .clear   (init || icd_ff),
      .tick    (qtick && ilcd_ff),
      .reached (lng_over)
   );

   reg nxt_icd;
   reg nxt_ilcd;

   always @*
   begin
      nxt_icd  = icd_ff;
      nxt_ilcd = ilcd_ff;
      if (init)
      begin
         nxt_icd  = 1'b0;
         nxt_ilcd = 1'b0;
      end
      else if (carrier_set_pulse)
      begin
         nxt_icd  = 1'b1;
         nxt_ilcd = 1'b1;
      end
      else
      begin
         if (icd_ff && rel_over)
            nxt_icd = 1'b0;
         if (ilcd_ff && !icd_ff && lng_over)
            nxt_ilcd = 1'b0;
      end
   end

   always @(posedge clock)
   begin
      if (!nrst)
      begin
         icd_ff  <= 1'b0;
         ilcd_ff <= 1'b0;
      end
      else
      begin
         icd_ff  <= nxt_icd;
         ilcd_ff <= nxt_ilcd;
      end
   end

   // Delay line in quarter bits; resolution is one error clock edge.
   reg [DLY_TICKS-1:0] cd_dly_ff;

   always @(posedge clock)
   begin
      if (!nrst || init)
         cd_dly_ff <= {DLY_TICKS{1'b0}};
      else if (qtick)
         cd_dly_ff <= {cd_dly_ff[DLY_TICKS-2:0], icd_ff};
   end

   // Pin outputs, all registered.
   reg nxt_oe_n;
   reg nxt_rxd;
   reg nxt_cd_n;
   reg nxt_fault;
   reg nxt_alarm_n;

   always @*
   begin
      nxt_oe_n    = 1'b1;
      nxt_rxd     = rx_level;
      // Initialization must show an idle carrier at once, not one cycle on.
      nxt_cd_n    = !icd_ff || init;
      nxt_fault   = fault_now;
      nxt_alarm_n = !nxt_jabber;
      case (mode)
         MODE_NORMAL:
         begin
            // Jabber inhibits the drivers until re-initialization.
            nxt_oe_n = !(tx_active && !nxt_jabber && !ctrl_inhibit_ff);
         end
         MODE_DELAY:
         begin
            nxt_oe_n = !(tx_active && !nxt_jabber && !ctrl_inhibit_ff);
            nxt_cd_n = !cd_dly_ff[DLY_TICKS-1] || init;
         end
         MODE_LOOP:
         begin
            nxt_rxd  = tx_data;
            nxt_cd_n = !tx_drive_enable;
         end
         MODE_LOOPF:
         begin
            nxt_rxd     = tx_data;
            nxt_cd_n    = !tx_drive_enable;
            nxt_fault   = 1'b1;
            nxt_alarm_n = 1'b0;
         end
         default:
         begin
            nxt_oe_n = 1'b1;
         end
      endcase
   end

   always @(posedge clock)
   begin
      if (!nrst)
      begin
         line_drv_p      <= 1'b0;
         line_drv_n      <= 1'b0;
         line_drv_oe_n   <= 1'b1;
         rx_data         <= 1'b0;
         carrier_sense_n <= 1'b1;
         tx_fault_flag   <= 1'b0;
         jabber_alarm_n  <= 1'b1;
      end
      else
      begin
         line_drv_p      <= tx_data;
         line_drv_n      <= !tx_data;
         line_drv_oe_n   <= nxt_oe_n;
         rx_data         <= nxt_rxd;
         carrier_sense_n <= nxt_cd_n;
         tx_fault_flag   <= nxt_fault;
         jabber_alarm_n  <= nxt_alarm_n;
      end
   end

   // Event capture; a new event beats a same-cycle software clear.
   reg [`FBD_EV_W-1:0] status_ff;
   reg [`FBD_EV_W-1:0] mask_ff;
   reg                 icd_q_ff;
   reg [`FBD_EV_W-1:0] ev_set;
   reg [`FBD_EV_W-1:0] ev_clr;

   always @*
   begin
      ev_set = `FBD_EV_RST;
      ev_set[`FBD_EV_SYMBOL]    = tx_active && sym_over;
      ev_set[`FBD_EV_OVERLOAD]  = drv_overload;
      ev_set[`FBD_EV_UNDERLOAD] = drv_underload;
      ev_set[`FBD_EV_JABBER]    = jab_over;
      ev_set[`FBD_EV_CARRIER]   = icd_ff && !icd_q_ff;
   end

   // APB slave, zero wait: ready is raised in the first access cycle.
   wire setup    = psel && !penable;
   wire complete = psel && penable && pready;
   wire wr_done  = complete && pwrite;
   reg  hit;
   reg  [31:0] rd_val;

   always @*
   begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         `FBD_REG_CTRL:
            rd_val[`FBD_CTRL_INHIBIT] = ctrl_inhibit_ff;
         `FBD_REG_STATUS:
            rd_val[`FBD_EV_W-1:0] = status_ff;
         `FBD_REG_MASK:
            rd_val[`FBD_EV_W-1:0] = mask_ff;
         `FBD_REG_STATE:
         begin
            rd_val[`FBD_ST_FAULT]   = tx_fault_flag;
            rd_val[`FBD_ST_JABBER]  = jabber_ff;
            rd_val[`FBD_ST_CARRIER] = icd_ff;
            rd_val[`FBD_ST_LONG]    = ilcd_ff;
            rd_val[`FBD_ST_SEL_A]   = test_sel_a;
            rd_val[`FBD_ST_SEL_B]   = test_sel_b;
         end
         default:
            hit = 1'b0;
      endcase
      ev_clr = `FBD_EV_RST;
      if (wr_done && paddr == `FBD_REG_STATUS)
         ev_clr = pwdata[`FBD_EV_W-1:0];
   end

   always @(posedge clock)
   begin
      if (!nrst)
      begin
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         prdata          <= 32'h0000_0000;
         ctrl_inhibit_ff <= `FBD_CTRL_RST;
         mask_ff         <= `FBD_EV_RST;
         status_ff       <= `FBD_EV_RST;
         icd_q_ff        <= 1'b0;
         irq             <= 1'b0;
      end
      else
      begin
         pready    <= setup;
         pslverr   <= setup && !hit;
         prdata    <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
         icd_q_ff  <= icd_ff;
         status_ff <= (status_ff & ~ev_clr) | ev_set;
         irq       <= |(((status_ff & ~ev_clr) | ev_set) & mask_ff);
         if (wr_done && paddr == `FBD_REG_CTRL)
            ctrl_inhibit_ff <= pwdata[`FBD_CTRL_INHIBIT];
         if (wr_done && paddr == `FBD_REG_MASK)
            mask_ff <= pwdata[`FBD_EV_W-1:0];
      end
   end

endmodule

`default_nettype wire

/* fbd_line_monitor_sva.sv */
// Port assertions for the line monitor.
`timescale 1ns/1ps
`default_nettype none

module fbd_line_monitor_sva
#(
   parameter JABBER_TICKS = 16384
)
(
   input wire logic clock,            // Clock.
   input wire logic nrst,             // Reset.
   input wire logic chip_init_n,      // Chip init.
   input wire logic test_sel_a,       // Select a.
   input wire logic test_sel_b,       // Select b.
   input wire logic error_detect_clk, // Quarter ticks.
   input wire logic half_bit_clk,     // Half ticks.
   input wire logic tx_data,          // Tx data.
   input wire logic tx_drive_enable,  // Tx enable.
   input wire logic drv_overload,     // Overload.
   input wire logic drv_underload,    // Underload.
   input wire logic rx_cmp,           // Comparator.
   input wire logic line_drv_oe_n,    // Driver enable.
   input wire logic rx_data,          // Rx data.
   input wire logic carrier_sense_n,  // Carrier.
   input wire logic tx_fault_flag,    // Fault.
   input wire logic jabber_alarm_n    // Jabber alarm.
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   logic        edc_ff;
   logic        hb_ff;
   logic        txd_ff;
   logic [4:0]  qt_ff;
   logic [3:0]  sym_ff;
   logic [15:0] jab_ff;
   wire         qtick = error_detect_clk ^ edc_ff;
   wire         hrise = half_bit_clk & ~hb_ff;
   wire         m00 = ~test_sel_a & ~test_sel_b;
   wire         run = ~test_sel_a & chip_init_n;

   // Any comparator activity restarts the idle count, so the release
   // bound is generous towards the design.
   always @(posedge clock)
   begin
      edc_ff <= error_detect_clk;
      hb_ff <= half_bit_clk;
      txd_ff <= tx_data;
      if (rx_cmp)
         qt_ff <= 5'h00;
      else if (!nrst || !chip_init_n)
         qt_ff <= 5'h10;
      else if (qtick && qt_ff != 5'h10)
         qt_ff <= qt_ff + 5'h01;
      if (!nrst || !chip_init_n || !tx_drive_enable || tx_data != txd_ff)
         sym_ff <= 4'h0;
      else if (hrise && sym_ff != 4'hf)
         sym_ff <= sym_ff + 4'h1;
      if (!nrst || !chip_init_n || !tx_drive_enable)
         jab_ff <= 16'h0000;
      else if (hrise && jab_ff != 16'hffff)
         jab_ff <= jab_ff + 16'h0001;
   end

   property p_drv_off;
      !tx_drive_enable |=> line_drv_oe_n;
   endproperty
   a_drv_off: assert property (p_drv_off) else $error("drivers on");
   property p_sym;
      run && tx_drive_enable && sym_ff == 4'ha |-> tx_fault_flag;
   endproperty
   a_sym: assert property (p_sym) else $error("no symbol fault");
   property p_load;
      run && tx_drive_enable && (drv_overload || drv_underload)
         |=> tx_fault_flag;
   endproperty
   a_load: assert property (p_load) else $error("no load fault");
   property p_jab;
      run && jab_ff == JABBER_TICKS + 1 |-> !jabber_alarm_n;
   endproperty
   a_jab: assert property (p_jab) else $error("no jabber alarm");
   property p_jab_hold;
      !jabber_alarm_n && chip_init_n && !(test_sel_a && test_sel_b)
         && !$past(test_sel_a && test_sel_b) |=> !jabber_alarm_n;
   endproperty
   a_jab_hold: assert property (p_jab_hold) else $error("alarm lost");
   property p_loop;
      test_sel_a && !test_sel_b && chip_init_n |=> rx_data == $past(tx_data)
         && carrier_sense_n == !$past(tx_drive_enable);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback wrong");
   property p_force;
      test_sel_a && test_sel_b
         |=> tx_fault_flag && !jabber_alarm_n && line_drv_oe_n;
   endproperty
   a_force: assert property (p_force) else $error("force wrong");
   property p_release;
      m00 && $past(m00) && chip_init_n && qt_ff == 5'h10 |-> carrier_sense_n;
   endproperty
   a_release: assert property (p_release) else $error("carrier held");
   property p_init;
      !chip_init_n && m00 && !drv_overload && !drv_underload
         |=> jabber_alarm_n && !tx_fault_flag && carrier_sense_n;
   endproperty
   a_init: assert property (p_init) else $error("init no clear");
endmodule

bind fbd_line_monitor fbd_line_monitor_sva #(.JABBER_TICKS(JABBER_TICKS))
   u_sva (.clock(clock), .nrst(nrst), .chip_init_n(chip_init_n),
   .test_sel_a(test_sel_a), .test_sel_b(test_sel_b),
   .error_detect_clk(error_detect_clk), .half_bit_clk(half_bit_clk),
   .tx_data(tx_data), .tx_drive_enable(tx_drive_enable),
   .drv_overload(drv_overload), .drv_underload(drv_underload),
   .rx_cmp(rx_cmp), .line_drv_oe_n(line_drv_oe_n), .rx_data(rx_data),
   .carrier_sense_n(carrier_sense_n), .tx_fault_flag(tx_fault_flag),
   .jabber_alarm_n(jabber_alarm_n));

`default_nettype wire

/* fbd_coproc_model.sv */
// Coprocessor model: bit clocks, transmit data and frame enable.
`timescale 1ns/1ps
`default_nettype none

module fbd_coproc_model
(
   input  wire logic clock,            // System clock.
   input  wire logic nrst,             // Reset, active low.
   input  wire logic frame_req,        // Bench asks for a frame.
   input  wire logic stuck,            // Hold the data still.
   output logic      error_detect_clk, // Quarter-bit edges.
   output logic      half_bit_clk,     // Half-bit rises.
   output logic      tx_data,          // Transmit data.
   output logic      tx_drive_enable   // Frame enable.
);
   logic [2:0] ph_ff;

   always @(posedge clock)
   begin
      ph_ff <= nrst ? ph_ff + 3'h1 : 3'h0;
      tx_drive_enable <= nrst & frame_req;
      if (!nrst)
         tx_data <= 1'b0;
      else if (!stuck && ph_ff == 3'h3)
         tx_data <= ~tx_data;
   end

   // A bit lasts sixteen system cycles: four edges, two half-bit rises.
   assign error_detect_clk = ph_ff[2];
   assign half_bit_clk = ph_ff[2] ^ ph_ff[1];
endmodule

`default_nettype wire

/* tb_fieldbus_line_driver_monitor.sv */
// Self-checking bench for the line monitor.
`timescale 1ns/1ps
`default_nettype none

module tb_fieldbus_line_driver_monitor;
   logic clock, nrst, chip_init_n, test_sel_a, test_sel_b, frame_req, stuck;
   logic drv_overload, drv_underload, rx_cmp, rx_level, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, m;
   logic d, e;
   wire [31:0] prdata;
   wire error_detect_clk, half_bit_clk, tx_data, tx_drive_enable;
   wire line_drv_p, line_drv_n, line_drv_oe_n, rx_data, carrier_sense_n;
   wire tx_fault_flag, jabber_alarm_n, irq, pready, pslverr;
   int n_mismatch, check_count, i;
   logic [32:0] exp_q[$];

   fbd_line_monitor #(.JABBER_TICKS(32)) uut (.clock(clock), .nrst(nrst),
      .chip_init_n(chip_init_n), .test_sel_a(test_sel_a),
      .test_sel_b(test_sel_b), .error_detect_clk(error_detect_clk),
      .half_bit_clk(half_bit_clk), .tx_data(tx_data),
      .tx_drive_enable(tx_drive_enable), .drv_overload(drv_overload),
      .drv_underload(drv_underload), .rx_cmp(rx_cmp), .rx_level(rx_level),
      .line_drv_p(line_drv_p), .line_drv_n(line_drv_n),
      .line_drv_oe_n(line_drv_oe_n), .rx_data(rx_data),
      .carrier_sense_n(carrier_sense_n), .tx_fault_flag(tx_fault_flag),
      .jabber_alarm_n(jabber_alarm_n), .irq(irq), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   fbd_coproc_model u_coproc (.clock(clock), .nrst(nrst),
      .frame_req(frame_req), .stuck(stuck),
      .error_detect_clk(error_detect_clk), .half_bit_clk(half_bit_clk),
      .tx_data(tx_data), .tx_drive_enable(tx_drive_enable));

   task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic step(int n);
      repeat (n) @(posedge clock);
   endtask

   // The leading edge keeps psel from being driven twice in one step.
   task automatic apb(bit w, logic [7:0] a, logic [31:0] dat);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [32:0] exp);
      exp_q.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask

   always @(posedge clock)
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("apb read", {pslverr, prdata}, exp_q.pop_front());

   always @(posedge clock)
      rx_level <= 1'($urandom);

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial
   begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      print_verdict;
   end

   initial
   begin
      {nrst, psel, penable, pwrite, frame_req, stuck} = 6'h00;
      {test_sel_a, test_sel_b, drv_overload, drv_underload, rx_cmp} = 5'h00;
      {chip_init_n, paddr, pwdata} = {1'b1, 8'h00, 32'h0};
      void'($urandom(32'h831f2a71));
      step(16);
      nrst <= 1'b1;
      step(1);
      chk("oe_n", line_drv_oe_n, 1);
      chk("alarm_n", jabber_alarm_n, 1);
      repeat (8)
      begin
         d = rx_level;
         step(1);
         chk("rx_data", rx_data, d);
      end
      rd(8'h0c, 33'h0);
      rd(8'h00, 33'h0);
      rd(8'h10, 33'h100000000);
      m = $urandom & 32'h1f;
      apb(1'b1, 8'h08, m);
      rd(8'h08, {1'b0, m});
      apb(1'b1, 8'h08, 32'h1f);
      frame_req <= 1'b1;
      step(4);
      chk("oe_n", line_drv_oe_n, 0);
      apb(1'b1, 8'h00, 32'h1);
      step(2);
      chk("oe_n inhibit", line_drv_oe_n, 1'h1);
      apb(1'b1, 8'h00, 32'h0);
      frame_req <= 1'b0;
      step(3);
      chk("oe_n", line_drv_oe_n, 1);
      {stuck, frame_req} <= 2'h3;
      step(100);
      chk("fault", tx_fault_flag, 1);
      chk("irq", irq, 1'h1);
      rd(8'h04, 33'h1);
      {stuck, frame_req} <= 2'h0;
      apb(1'b1, 8'h04, 32'h1);
      step(2);
      chk("irq", irq, 1'h0);
      for (i = 1; i <= 2; i++)
      begin
         frame_req <= 1'b1;
         step(3);
         {drv_underload, drv_overload} <= 2'(i);
         step(2);
         chk("fault", tx_fault_flag, 1);
         rd(8'h04, i == 1 ? 33'h2 : 33'h4);
         {drv_overload, drv_underload, frame_req} <= 3'h0;
         apb(1'b1, 8'h04, 32'h1f);
      end
      frame_req <= 1'b1;
      step(270);
      chk("alarm_n", jabber_alarm_n, 0);
      chk("oe_n", line_drv_oe_n, 1);
      frame_req <= 1'b0;
      step(20);
      chk("alarm_n", jabber_alarm_n, 0);
      rd(8'h0c, 33'h2);
      rd(8'h04, 33'h8);
      chip_init_n <= 1'b0;
      step(2);
      chip_init_n <= 1'b1;
      step(1);
      chk("alarm_n", jabber_alarm_n, 1);
      apb(1'b1, 8'h04, 32'h1f);
      rx_cmp <= 1'b1;
      step(2);
      rx_cmp <= 1'b0;
      step(20);
      chk("carrier glitch", carrier_sense_n, 1);
      rx_cmp <= 1'b1;
      step(12);
      rx_cmp <= 1'b0;
      step(2);
      chk("carrier", carrier_sense_n, 0);
      rd(8'h04, 33'h10);
      rd(8'h0c, 33'hc);
      step(30);
      chk("carrier", carrier_sense_n, 0);
      step(40);
      chk("carrier", carrier_sense_n, 1);
      rd(8'h0c, 33'h8);
      step(90);
      rd(8'h0c, 33'h0);
      test_sel_b <= 1'b1;
      step(2);
      rx_cmp <= 1'b1;
      step(12);
      rx_cmp <= 1'b0;
      step(40);
      chk("carrier delayed", carrier_sense_n, 1);
      step(70);
      chk("carrier delayed", carrier_sense_n, 0);
      step(250);
      for (i = 0; i < 2; i++)
      begin
         {test_sel_a, test_sel_b} <= {1'b1, 1'(i)};
         step(2);
         repeat (24)
         begin
            frame_req <= 1'($urandom);
            d = tx_data;
            e = tx_drive_enable;
            step(1);
            chk("rx_data", rx_data, d);
            chk("carrier", carrier_sense_n, !e);
            chk("oe_n", line_drv_oe_n, 1);
            chk("drivers", {line_drv_p, line_drv_n}, {d, !d});
            if (i == 1)
               chk("forced", {tx_fault_flag, jabber_alarm_n}, 2'h2);
         end
      end
      print_verdict;
   end
endmodule

`default_nettype wire
